//--- dfscs_pkg.sv
// constants, carriers and state layout of the display, fan and sensor command block
package dfscs_pkg;
  // ****************************************************************
  // command codes and response types
  // ****************************************************************
  localparam logic [5:0] CMD_GLYPH   = 6'h09;
  localparam logic [5:0] CMD_MEMRD   = 6'h0a;
  localparam logic [5:0] CMD_CURPOS  = 6'h0b;
  localparam logic [5:0] CMD_CURSTY  = 6'h0c;
  localparam logic [5:0] CMD_CONTR   = 6'h0d;
  localparam logic [5:0] CMD_BLIGHT  = 6'h0e;
  localparam logic [5:0] CMD_FANRPT  = 6'h10;
  localparam logic [5:0] CMD_FANPWR  = 6'h11;
  localparam logic [5:0] CMD_DEVINF  = 6'h12;
  localparam logic [5:0] CMD_TEMPEN  = 6'h13;
  localparam logic [1:0] KIND_CMD    = 2'h0;
  localparam logic [1:0] RSP_OK      = 2'h1;
  localparam logic [1:0] RSP_ERR     = 2'h3;
  localparam logic [7:0] RPT_FAN     = 8'h81;
  // ****************************************************************
  // lengths, ranges and field positions
  // ****************************************************************
  localparam logic [4:0] LEN_ZERO    = 5'h00;
  localparam logic [4:0] LEN_ONE     = 5'h01;
  localparam logic [4:0] LEN_TWO     = 5'h02;
  localparam logic [4:0] LEN_FOUR    = 5'h04;
  localparam logic [4:0] LEN_NINE    = 5'h09;
  localparam logic [7:0] GLY_LO      = 8'h40;
  localparam logic [7:0] GLY_HI      = 8'h7f;
  localparam logic [4:0] SCR_COL_MAX = 5'h13;
  localparam int         SCR_BIT     = 7;
  localparam logic [7:0] COL_MAX     = 8'h13;
  localparam logic [7:0] ROW_MAX     = 8'h03;
  localparam logic [7:0] STYLE_MAX   = 8'h03;
  localparam logic [7:0] PCT_MAX     = 8'h64;
  localparam logic [7:0] GLYPH_MAX   = 8'h07;
  localparam logic [7:0] DEV_MAX     = 8'h1f;
  localparam logic [7:0] PIX_MASK    = 8'h3f;
  localparam int         BLINK_BIT   = 7;
  localparam logic [3:0] ROWS_LAST   = 4'h7;
  localparam logic [3:0] ROWS_ALL    = 4'h8;
  localparam logic [3:0] FAN_MASK    = 4'h7;
  localparam logic [1:0] FAN_UNUSED  = 2'h3;
  localparam logic [7:0] CONTR_NOM   = 8'h5f;
  localparam int         NFAN        = 4;
  localparam int         NDEV        = 32;
  // family codes of the two supported temperature sensors: values are arbitrary
  localparam logic [7:0] FAM_TEMP_A  = 8'h5a;
  localparam logic [7:0] FAM_TEMP_B  = 8'h5b;
  // ****************************************************************
  // timing: one report slot is an eighth of a second
  // ****************************************************************
  localparam int         CLK_NS      = 10;
  localparam int         SLOT_MS     = 125;
  localparam int         SLOT_CYC    = SLOT_MS * 1000000 / CLK_NS;
  localparam logic [2:0] SLOT_TEMP   = 3'h0;
  // ****************************************************************
  // carriers and state
  // ****************************************************************
  typedef enum logic [4:0] {
    S_IDLE = 5'b00001,
    S_GWR  = 5'b00010,
    S_MRD  = 5'b00100,
    S_RESP = 5'b01000,
    S_SPARE = 5'b10000
  } dfscs_fsm_e;
  typedef struct packed {
    logic            valid;
    logic [7:0]      kind;
    logic [4:0]      len;
    logic [8:0][7:0] data;
  } dfscs_pkt_s;
  typedef struct packed {
    logic       valid;
    logic [7:0] kind;
    logic [1:0] fan;
  } dfscs_rpt_s;
  typedef struct packed {
    logic        valid;
    logic [4:0]  idx;
    logic [63:0] id;
  } dfscs_enum_s;
  typedef struct packed {
    logic [63:0]     blink;
    logic [7:0]      col;
    logic [7:0]      row;
    logic [1:0]      style;
    logic [7:0]      contrast;
    logic [7:0]      backlight;
    logic [3:0][7:0] fan;
  } dfscs_boot_s;
  typedef struct packed {
    dfscs_fsm_e       fsm;
    logic             loaded;
    dfscs_pkt_s       cmd;
    dfscs_pkt_s       rsp;
    logic [3:0]       cnt;
    logic [3:0]       cap;
    logic [7:0]       mem_addr;
    logic             mem_we;
    logic             mem_re;
    logic [7:0]       mem_wdata;
    logic             rd_pend;
    dfscs_boot_s      cfg;
    dfscs_boot_s      boot_q;
    logic             boot_save;
    logic [3:0]       fan_mask;
    logic [31:0]      temp_mask;
    logic [31:0]      temp_en;
    logic [31:0][63:0] ids;
    logic [31:0]      present;
    logic             enum_done;
    logic [23:0]      tick_cnt;
    logic [2:0]       slot;
    logic [3:0]       force_full;
    logic [3:0][7:0]  fan_out;
    dfscs_rpt_s       fan_rpt;
    logic             temp_scan;
  } dfscs_state_s;
endpackage

//--- dfscs_top.sv
// command interpreter for glyph, memory readback, cursor, contrast, backlight, fan and sensor commands
`timescale 1ns/1ps
module dfscs_top #(
  parameter int TICK_CYC = dfscs_pkg::SLOT_CYC  // cycles in one eighth-second slot
) (
  input  wire logic                  CLK_I,          // 100 MHz clock
  input  wire logic                  NRST_I,         // async reset, active low
  input  wire dfscs_pkg::dfscs_pkt_s CMD_I,          // decoded command packet
  output logic                       CMD_READY_O,    // command accepted when high
  output dfscs_pkg::dfscs_pkt_s      RSP_O,          // response packet
  input  wire logic                  RSP_READY_I,    // response taken when high
  output logic [7:0]                 MEM_ADDR_O,     // display memory address code
  output logic                       MEM_WE_O,       // display memory write strobe
  output logic [7:0]                 MEM_WDATA_O,    // display memory write data
  output logic                       MEM_RE_O,       // display memory read strobe
  input  wire logic [7:0]            MEM_RDATA_I,    // read data, cycle after strobe
  output logic [63:0]                GLYPH_BLINK_O,  // blink flag per glyph row
  output logic [7:0]                 CURSOR_COL_O,   // cursor column
  output logic [7:0]                 CURSOR_ROW_O,   // cursor row
  output logic [1:0]                 CURSOR_STYLE_O, // cursor appearance
  output logic [7:0]                 CONTRAST_O,     // contrast level
  output logic [7:0]                 BACKLIGHT_O,    // backlight level
  output logic [3:0][7:0]            FAN_PWR_O,      // effective fan power, percent
  output dfscs_pkg::dfscs_rpt_s      FAN_RPT_O,      // fan report request pulse
  output logic                       TEMP_SCAN_O,    // once-per-second sensor pulse
  output logic [31:0]                TEMP_EN_O,      // sensors cleared for reporting
  input  wire dfscs_pkg::dfscs_enum_s ENUM_I,        // enumerated bus device
  input  wire logic                  ENUM_DONE_I,    // enumeration finished
  input  wire logic                  STORE_I,        // store-boot-state pulse
  output logic                       BOOT_SAVE_O,    // save snapshot pulse
  output dfscs_pkg::dfscs_boot_s     BOOT_STATE_O,   // snapshot to store
  input  wire dfscs_pkg::dfscs_boot_s BOOT_STATE_I   // stored boot state
);

  localparam logic [23:0] TICK_LAST = 24'(TICK_CYC - 1);

  dfscs_pkg::dfscs_state_s st_r;
  dfscs_pkg::dfscs_state_s st_nxt;

  // ****************************************************************
  // address code check for readback
  // ****************************************************************
  function automatic logic addr_ok(input logic [7:0] a);
    logic gly;
    logic scr;
    gly = (a >= dfscs_pkg::GLY_LO) && (a <= dfscs_pkg::GLY_HI);
    scr = a[dfscs_pkg::SCR_BIT] && (a[4:0] <= dfscs_pkg::SCR_COL_MAX);
    return gly || scr;
  endfunction

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    logic            ok;
    logic [2:0]      nslot;
    logic [1:0]      fk;
    logic [3:0]      ri;
    logic [5:0]      bi;
    logic [7:0]      fam;
    logic [4:0]      di;
    ok    = 1'b0;
    nslot = 3'h0;
    fk    = 2'h0;
    ri    = 4'h0;
    bi    = 6'h0;
    fam   = 8'h00;
    di    = 5'h00;
    st_nxt = st_r;
    st_nxt.mem_we    = 1'b0;
    st_nxt.mem_re    = 1'b0;
    st_nxt.rd_pend   = st_r.mem_re;
    st_nxt.boot_save = 1'b0;
    st_nxt.fan_rpt   = '0;
    st_nxt.temp_scan = 1'b0;

    // settings come up from the stored boot state after release
    if (!st_r.loaded) begin
      st_nxt.cfg    = BOOT_STATE_I;
      st_nxt.loaded = 1'b1;
    end

    // capture bus devices while power-up enumeration runs
    if (!st_r.enum_done) begin
      if (ENUM_I.valid) begin
        st_nxt.ids[ENUM_I.idx]     = ENUM_I.id;
        st_nxt.present[ENUM_I.idx] = 1'b1;
      end
      st_nxt.enum_done = ENUM_DONE_I;
    end

    // snapshot of the savable settings
    if (STORE_I) begin
      st_nxt.boot_q    = st_r.cfg;
      st_nxt.boot_save = 1'b1;
    end

    // eighth-second slots: fan k owns slot k of each half second
    if (st_r.tick_cnt == TICK_LAST) begin
      st_nxt.tick_cnt   = 24'h000000;
      nslot             = st_r.slot + 3'h1;
      st_nxt.slot       = nslot;
      fk                = nslot[1:0];
      st_nxt.force_full = 4'h0;
      if (st_r.fan_mask[fk] && (fk != dfscs_pkg::FAN_UNUSED)) begin
        st_nxt.fan_rpt.valid  = 1'b1;
        st_nxt.fan_rpt.kind   = dfscs_pkg::RPT_FAN;
        st_nxt.fan_rpt.fan    = fk;
        st_nxt.force_full[fk] = 1'b1;
      end
      st_nxt.temp_scan = (nslot == dfscs_pkg::SLOT_TEMP) && (st_r.temp_en != 32'h00000000);
    end else begin
      st_nxt.tick_cnt = st_r.tick_cnt + 24'h000001;
    end

    // command sequencer
    case (st_r.fsm)
      dfscs_pkg::S_IDLE: begin
        if (CMD_I.valid && st_r.loaded) begin
          st_nxt.cmd      = CMD_I;
          st_nxt.rsp      = '0;
          st_nxt.rsp.kind = {dfscs_pkg::RSP_OK, CMD_I.kind[5:0]};
          st_nxt.rsp.len  = dfscs_pkg::LEN_ZERO;
          st_nxt.fsm      = dfscs_pkg::S_RESP;
          st_nxt.cnt      = 4'h0;
          st_nxt.cap      = 4'h0;
          if (CMD_I.kind[7:6] == dfscs_pkg::KIND_CMD) begin
            case (CMD_I.kind[5:0])
              dfscs_pkg::CMD_GLYPH: begin
                if ((CMD_I.len == dfscs_pkg::LEN_NINE) && (CMD_I.data[0] <= dfscs_pkg::GLYPH_MAX)) begin
                  ok         = 1'b1;
                  st_nxt.fsm = dfscs_pkg::S_GWR;
                end
              end
              dfscs_pkg::CMD_MEMRD: begin
                if ((CMD_I.len == dfscs_pkg::LEN_ONE) && addr_ok(CMD_I.data[0])) begin
                  ok                 = 1'b1;
                  st_nxt.rsp.len     = dfscs_pkg::LEN_NINE;
                  st_nxt.rsp.data[0] = CMD_I.data[0];
                  st_nxt.fsm         = dfscs_pkg::S_MRD;
                end
              end
              dfscs_pkg::CMD_CURPOS: begin
                if ((CMD_I.len == dfscs_pkg::LEN_TWO) && (CMD_I.data[0] <= dfscs_pkg::COL_MAX) &&
                    (CMD_I.data[1] <= dfscs_pkg::ROW_MAX)) begin
                  ok             = 1'b1;
                  st_nxt.cfg.col = CMD_I.data[0];
                  st_nxt.cfg.row = CMD_I.data[1];
                end
              end
              dfscs_pkg::CMD_CURSTY: begin
                if ((CMD_I.len == dfscs_pkg::LEN_ONE) && (CMD_I.data[0] <= dfscs_pkg::STYLE_MAX)) begin
                  ok               = 1'b1;
                  st_nxt.cfg.style = CMD_I.data[0][1:0];
                end
              end
              dfscs_pkg::CMD_CONTR: begin
                if (CMD_I.len == dfscs_pkg::LEN_ONE) begin
                  ok                  = 1'b1;
                  st_nxt.cfg.contrast = CMD_I.data[0];
                end
              end
              dfscs_pkg::CMD_BLIGHT: begin
                if ((CMD_I.len == dfscs_pkg::LEN_ONE) && (CMD_I.data[0] <= dfscs_pkg::PCT_MAX)) begin
                  ok                   = 1'b1;
                  st_nxt.cfg.backlight = CMD_I.data[0];
                end
              end
              dfscs_pkg::CMD_FANRPT: begin
                if (CMD_I.len == dfscs_pkg::LEN_ONE) begin
                  ok              = 1'b1;
                  st_nxt.fan_mask = CMD_I.data[0][3:0] & dfscs_pkg::FAN_MASK;
                end
              end
              dfscs_pkg::CMD_FANPWR: begin
                if ((CMD_I.len == dfscs_pkg::LEN_FOUR) && (CMD_I.data[0] <= dfscs_pkg::PCT_MAX) &&
                    (CMD_I.data[1] <= dfscs_pkg::PCT_MAX) && (CMD_I.data[2] <= dfscs_pkg::PCT_MAX) &&
                    (CMD_I.data[3] <= dfscs_pkg::PCT_MAX)) begin
                  ok = 1'b1;
                  for (int k = 0; k < dfscs_pkg::NFAN; k++) begin
                    st_nxt.cfg.fan[k] = CMD_I.data[k];
                  end
                end
              end
              dfscs_pkg::CMD_DEVINF: begin
                if ((CMD_I.len == dfscs_pkg::LEN_ONE) && (CMD_I.data[0] <= dfscs_pkg::DEV_MAX)) begin
                  ok                 = 1'b1;
                  di                 = CMD_I.data[0][4:0];
                  st_nxt.rsp.len     = dfscs_pkg::LEN_NINE;
                  st_nxt.rsp.data[0] = CMD_I.data[0];
                  for (int b = 0; b < 8; b++) begin
                    st_nxt.rsp.data[b + 1] = st_r.ids[di][b*8 +: 8];
                  end
                end
              end
              dfscs_pkg::CMD_TEMPEN: begin
                if (CMD_I.len == dfscs_pkg::LEN_FOUR) begin
                  ok               = 1'b1;
                  st_nxt.temp_mask = {CMD_I.data[3], CMD_I.data[2], CMD_I.data[1], CMD_I.data[0]};
                end
              end
              default: begin
                ok = 1'b0;
              end
            endcase
          end
          // refused commands leave the settings as they were
          if (!ok) begin
            st_nxt.cfg       = st_r.cfg;
            st_nxt.fan_mask  = st_r.fan_mask;
            st_nxt.temp_mask = st_r.temp_mask;
            st_nxt.rsp       = '0;
            st_nxt.rsp.kind  = {dfscs_pkg::RSP_ERR, CMD_I.kind[5:0]};
            st_nxt.fsm       = dfscs_pkg::S_RESP;
          end
          st_nxt.rsp.valid = (st_nxt.fsm == dfscs_pkg::S_RESP);
        end
      end
      dfscs_pkg::S_GWR: begin
        // one row per cycle, top row first
        ri                   = st_r.cnt + 4'h1;
        bi                   = {st_r.cmd.data[0][2:0], st_r.cnt[2:0]};
        st_nxt.mem_we        = 1'b1;
        st_nxt.mem_addr      = dfscs_pkg::GLY_LO + {2'h0, bi};
        st_nxt.mem_wdata     = st_r.cmd.data[ri] & dfscs_pkg::PIX_MASK;
        st_nxt.cfg.blink[bi] = st_r.cmd.data[ri][dfscs_pkg::BLINK_BIT];
        st_nxt.cnt           = ri;
        if (st_r.cnt == dfscs_pkg::ROWS_LAST) begin
          st_nxt.rsp.valid = 1'b1;
          st_nxt.fsm       = dfscs_pkg::S_RESP;
        end
      end
      dfscs_pkg::S_MRD: begin
        // issue eight reads, gather each one cycle later
        if (st_r.cnt != dfscs_pkg::ROWS_ALL) begin
          st_nxt.mem_re   = 1'b1;
          st_nxt.mem_addr = st_r.cmd.data[0] + {4'h0, st_r.cnt};
          st_nxt.cnt      = st_r.cnt + 4'h1;
        end
        if (st_r.rd_pend) begin
          st_nxt.rsp.data[st_r.cap + 4'h1] = MEM_RDATA_I;
          st_nxt.cap                       = st_r.cap + 4'h1;
          if (st_r.cap == dfscs_pkg::ROWS_LAST) begin
            st_nxt.rsp.valid = 1'b1;
            st_nxt.fsm       = dfscs_pkg::S_RESP;
          end
        end
      end
      dfscs_pkg::S_RESP: begin
        if (RSP_READY_I) begin
          st_nxt.rsp.valid = 1'b0;
          st_nxt.fsm       = dfscs_pkg::S_IDLE;
        end
      end
      default: begin
        st_nxt.fsm = dfscs_pkg::S_IDLE;
      end
    endcase

    // only detected sensors of the two supported families may report
    for (int d = 0; d < dfscs_pkg::NDEV; d++) begin
      fam = st_r.ids[d][7:0];
      st_nxt.temp_en[d] = st_r.temp_mask[d] && st_r.present[d] &&
                          ((fam == dfscs_pkg::FAM_TEMP_A) || (fam == dfscs_pkg::FAM_TEMP_B));
    end

    // effective fan power with report override and dead fourth channel
    for (int k = 0; k < dfscs_pkg::NFAN; k++) begin
      if (k == int'(dfscs_pkg::FAN_UNUSED)) begin
        st_nxt.fan_out[k] = 8'h00;
      end else if (st_nxt.force_full[k]) begin
        st_nxt.fan_out[k] = dfscs_pkg::PCT_MAX;
      end else begin
        st_nxt.fan_out[k] = st_nxt.cfg.fan[k];
      end
    end
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      st_r              <= '0;
      st_r.fsm          <= dfscs_pkg::S_IDLE;
      st_r.cfg.contrast <= dfscs_pkg::CONTR_NOM;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  // command ready decoded from the registered state, everything else straight from the state register
  assign CMD_READY_O    = (st_r.fsm == dfscs_pkg::S_IDLE) && st_r.loaded;
  assign RSP_O          = st_r.rsp;
  assign MEM_ADDR_O     = st_r.mem_addr;
  assign MEM_WE_O       = st_r.mem_we;
  assign MEM_WDATA_O    = st_r.mem_wdata;
  assign MEM_RE_O       = st_r.mem_re;
  assign GLYPH_BLINK_O  = st_r.cfg.blink;
  assign CURSOR_COL_O   = st_r.cfg.col;
  assign CURSOR_ROW_O   = st_r.cfg.row;
  assign CURSOR_STYLE_O = st_r.cfg.style;
  assign CONTRAST_O     = st_r.cfg.contrast;
  assign BACKLIGHT_O    = st_r.cfg.backlight;
  assign FAN_PWR_O      = st_r.fan_out;
  assign FAN_RPT_O      = st_r.fan_rpt;
  assign TEMP_SCAN_O    = st_r.temp_scan;
  assign TEMP_EN_O      = st_r.temp_en;
  assign BOOT_SAVE_O    = st_r.boot_save;
  assign BOOT_STATE_O   = st_r.boot_q;

endmodule // dfscs_top

//--- dfscs_chk_sva.sv
// assertions on the ports of the command block
`timescale 1ns/1ps
module dfscs_chk (
  input wire logic                  CLK_I,       // clock
  input wire logic                  NRST_I,      // reset, active low
  input wire dfscs_pkg::dfscs_pkt_s CMD_I,       // command
  input wire logic                  CMD_READY_O, // command ready
  input wire dfscs_pkg::dfscs_pkt_s RSP_O,       // response
  input wire logic                  RSP_READY_I, // response taken
  input wire logic                  MEM_WE_O,    // write strobe
  input wire logic                  MEM_RE_O,    // read strobe
  input wire logic [7:0]            CONTRAST_O,  // contrast
  input wire logic [3:0][7:0]       FAN_PWR_O,   // fan power
  input wire dfscs_pkg::dfscs_rpt_s FAN_RPT_O,   // fan report
  input wire logic                  STORE_I,     // store pulse
  input wire logic                  BOOT_SAVE_O  // save pulse
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!NRST_I);
  wire take = CMD_I.valid && CMD_READY_O;
  // glyph rows written and memory bytes read, eight in a row
  sequence wr_rows; MEM_WE_O [*8]; endsequence
  sequence rd_rows; MEM_RE_O [*8]; endsequence
  AST_RSP_KIND: assert property (RSP_O.valid |-> RSP_O.kind[6]) else $error("response type lacks bit 6");
  AST_RSP_HOLD: assert property (RSP_O.valid && !RSP_READY_I |=> $stable(RSP_O)) else $error("response moved");
  AST_BUSY: assert property (RSP_O.valid |-> !CMD_READY_O) else $error("ready while answering");
  AST_GLYPH: assert property (take && CMD_I.kind == 8'h09 && CMD_I.len == 5'h09 && CMD_I.data[0] < 8'h08
    |-> ##2 wr_rows ##0 RSP_O.valid) else $error("glyph rows not written");
  AST_MRD: assert property (take && CMD_I.kind == 8'h0a && CMD_I.len == 5'h01 && CMD_I.data[0][7:6] == 2'h1
    |-> ##2 rd_rows ##2 (RSP_O.valid && RSP_O.len == 5'h09)) else $error("readback wrong");
  AST_CONTR: assert property (take && CMD_I.kind == 8'h0d && CMD_I.len == 5'h01
    |=> RSP_O.kind == 8'h4d && CONTRAST_O == $past(CMD_I.data[0])) else $error("contrast not set");
  AST_FAN3: assert property (FAN_PWR_O[3] == 8'h00) else $error("fourth fan powered");
  AST_FAN_PCT: assert property (FAN_PWR_O[0] <= 8'h64 && FAN_PWR_O[1] <= 8'h64 && FAN_PWR_O[2] <= 8'h64)
    else $error("fan power above full");
  AST_FORCE: assert property (FAN_RPT_O.valid |-> FAN_RPT_O.kind == 8'h81 && FAN_PWR_O[FAN_RPT_O.fan] == 8'h64)
    else $error("reported fan not at full");
  AST_RPT_PULSE: assert property (FAN_RPT_O.valid |=> !FAN_RPT_O.valid) else $error("report not a pulse");
  AST_STORE: assert property (STORE_I |=> BOOT_SAVE_O) else $error("store not saved");
endmodule // dfscs_chk
bind dfscs_top dfscs_chk dfscs_chk_inst (.CLK_I(CLK_I), .NRST_I(NRST_I), .CMD_I(CMD_I), .CMD_READY_O(CMD_READY_O),
  .RSP_O(RSP_O), .RSP_READY_I(RSP_READY_I), .MEM_WE_O(MEM_WE_O), .MEM_RE_O(MEM_RE_O), .CONTRAST_O(CONTRAST_O),
  .FAN_PWR_O(FAN_PWR_O), .FAN_RPT_O(FAN_RPT_O), .STORE_I(STORE_I), .BOOT_SAVE_O(BOOT_SAVE_O));

//--- dfscs_host.sv
// host model: sends one command and takes its answer
`timescale 1ns/1ps
module dfscs_host (
  input  wire logic                  CLK_I,       // clock
  input  wire logic                  CMD_READY_I, // command accepted
  input  wire dfscs_pkg::dfscs_pkt_s RSP_I,       // response
  output dfscs_pkg::dfscs_pkt_s      CMD_O,       // command
  output logic                       RSP_READY_O  // response taken
);
  initial begin
    CMD_O = '0;
    RSP_READY_O = 1'b0;
  end
  // one command at a time; answer taken a cycle late to exercise the hold
  task automatic xfer(input logic [7:0] k, input logic [4:0] l, input logic [71:0] d,
                      output dfscs_pkg::dfscs_pkt_s r);
    @(posedge CLK_I);
    CMD_O <= {1'b1, k, l, d};
    do @(posedge CLK_I); while (CMD_READY_I !== 1'b1);
    CMD_O <= {1'b0, k, l, ~d}; // released data no longer valid
    do @(posedge CLK_I); while (RSP_I.valid !== 1'b1);
    RSP_READY_O <= 1'b1;
    @(posedge CLK_I);
    r = RSP_I;
    RSP_READY_O <= 1'b0;
  endtask
endmodule // dfscs_host

//--- display_fan_sensor_command_set_bench.sv
// self-checking bench of the command block
`timescale 1ns/1ps
module display_fan_sensor_command_set_bench;
  logic clk = 0, nrst = 0, store = 0, done = 0, rdy, ready, we, re, save, scan;
  logic [7:0] rdata = '0, addr, wdata, col, row, con, bl;
  logic [1:0] sty;
  logic [63:0] blink;
  logic [31:0] ten;
  logic [3:0][7:0] fan;
  logic [15:0] wq[$];
  int mismatches = 0, check_count = 0;
  dfscs_pkg::dfscs_pkt_s cmd, rsp, r;
  dfscs_pkg::dfscs_rpt_s rpt;
  dfscs_pkg::dfscs_enum_s enm = '0;
  dfscs_pkg::dfscs_boot_s boot = '0, snap;
  logic [7:0] ra[3] = '{8'h40, 8'h80, 8'he0};
  always #5 clk = ~clk;
  // display memory: data a cycle after the read strobe, noise otherwise
  always @(posedge clk) rdata <= re ? addr ^ 8'h5a : ~rdata;
  always @(posedge clk) if (we) wq.push_back({addr, wdata});
  dfscs_top #(.TICK_CYC(16)) dfscs_top_inst (.CLK_I(clk), .NRST_I(nrst), .CMD_I(cmd), .CMD_READY_O(ready),
    .RSP_O(rsp), .RSP_READY_I(rdy), .MEM_ADDR_O(addr), .MEM_WE_O(we), .MEM_WDATA_O(wdata), .MEM_RE_O(re),
    .MEM_RDATA_I(rdata), .GLYPH_BLINK_O(blink), .CURSOR_COL_O(col), .CURSOR_ROW_O(row), .CURSOR_STYLE_O(sty),
    .CONTRAST_O(con), .BACKLIGHT_O(bl), .FAN_PWR_O(fan), .FAN_RPT_O(rpt), .TEMP_SCAN_O(scan), .TEMP_EN_O(ten),
    .ENUM_I(enm), .ENUM_DONE_I(done), .STORE_I(store), .BOOT_SAVE_O(save), .BOOT_STATE_O(snap),
    .BOOT_STATE_I(boot));
  dfscs_host host_inst (.CLK_I(clk), .CMD_READY_I(ready), .RSP_I(rsp), .CMD_O(cmd), .RSP_READY_O(rdy));
  task automatic chk(input string n, input logic [71:0] e, a);
    check_count++;
    if (e !== a) begin
      mismatches++;
      $display("Error %s expected %h seen %h", n, e, a);
    end
  endtask
  task automatic send(input logic [7:0] k, input logic [4:0] l, input logic [71:0] d, input logic [7:0] ek);
    host_inst.xfer(k, l, d, r);
    chk("response type", ek, r.kind);
  endtask
  task automatic stop_test;
    if (mismatches == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #50000;
    mismatches++;
    stop_test;
  end
  initial begin
    boot.contrast = 8'h5f;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    // enumeration reports devices 5, 6 and 9; only 5 and 9 carry a supported sensor family code
    @(posedge clk) enm <= {1'b1, 5'h05, 64'hc1c2c3c4c5c6c75a};
    @(posedge clk) enm <= {1'b1, 5'h06, 64'h0102030405060711};
    @(posedge clk) enm <= {1'b1, 5'h09, 64'h0a0b0c0d0e0f015b};
    @(posedge clk) enm <= '0;
    done <= 1'b1;
    send(8'h0b, 5'h02, 72'h0313, 8'h4b);
    chk("cursor", 16'h1303, {col, row});
    send(8'h4b, 5'h02, 72'h0000, 8'hcb);
    send(8'h0b, 5'h02, 72'h0014, 8'hcb);
    chk("cursor", 16'h1303, {col, row});
    send(8'h0c, 5'h01, 72'h03, 8'h4c);
    chk("style", 2'h3, sty);
    send(8'h0d, 5'h01, 72'hff, 8'h4d);
    chk("contrast", 8'hff, con);
    send(8'h0e, 5'h01, 72'h32, 8'h4e);
    chk("backlight", 8'h32, bl);
    send(8'h11, 5'h04, 72'h4d076432, 8'h51);
    chk("fan power", 32'h00076432, fan);
    send(8'h11, 5'h04, 72'h00006532, 8'hd1);
    send(8'h11, 5'h03, 72'h006432, 8'hd1);
    chk("fan power", 32'h00076432, fan);
    send(8'h0f, 5'h00, 72'h00, 8'hcf);
    wq.delete();
    send(8'h09, 5'h09, 72'h2a000000000000bf01, 8'h49);
    chk("first row", 16'h483f, wq[0]);
    chk("last row", 16'h4f2a, wq[7]);
    chk("blink", 1'b1, blink[8]);
    foreach (ra[i]) begin
      send(8'h0a, 5'h01, {64'h0, ra[i]}, 8'h4a);
      chk("echo", {5'h09, ra[i]}, {r.len, r.data[0]});
      chk("bytes", {ra[i] ^ 8'h5a, (ra[i] + 8'h07) ^ 8'h5a}, {r.data[1], r.data[8]});
    end
    send(8'h12, 5'h01, 72'h05, 8'h52);
    chk("device id", 72'hc1c2c3c4c5c6c75a05, r.data);
    send(8'h12, 5'h01, 72'h20, 8'hd2);
    send(8'h13, 5'h04, 72'h00000260, 8'h53);
    repeat (2) @(posedge clk);
    chk("temp enable", 32'h00000220, ten);
    for (int i = 0; i < 200 && scan !== 1'b1; i++) @(posedge clk);
    chk("temp scan", 1'b1, scan);
    store <= 1'b1;
    @(posedge clk) store <= 1'b0;
    repeat (2) @(posedge clk);
    chk("snapshot", 16'hff32, {snap.contrast, snap.backlight});
    send(8'h10, 5'h01, 72'h0f, 8'h50);
    for (int i = 0; i < 300 && rpt.valid !== 1'b1; i++) @(posedge clk);
    chk("report", 9'h181, {rpt.valid, rpt.kind});
    repeat (100) @(posedge clk);
    stop_test;
  end
endmodule // display_fan_sensor_command_set_bench
